/* File: pkg/rwsc_pkg.sv */
// Purpose: Constants and types for the reset, watchdog and sleep controller.
// Assumes: 50 MHz ref_clk; register port with one-cycle read latency.
package rwsc_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned RST_TIMER_MS = 18;
  localparam int unsigned WDT_MS = 18;
  localparam int unsigned RST_TIMER_CYCLES = CLK_HZ / 1000 * RST_TIMER_MS;
  localparam int unsigned WDT_CYCLES = CLK_HZ / 1000 * WDT_MS;

  localparam logic [3:0] ADDR_OPTION = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_CTRL = 4'h2;
  localparam logic [7:0] OPTION_RESET = 8'hff;
  localparam int unsigned OPT_WAKE_BIT = 7;
  localparam int unsigned OPT_ASSIGN_BIT = 3;
  localparam int unsigned STAT_PCW_BIT = 7;
  localparam int unsigned STAT_TIMEOUT_BIT = 4;
  localparam int unsigned STAT_POWERDOWN_BIT = 3;

  localparam logic [9:0] PROG_LAST = 10'h3ff;
  localparam logic [9:0] PROG_OPEN_LIMIT = 10'h040;
  localparam logic [11:0] ID_UPPER_MASK = 12'h00f;

  typedef struct packed {
    logic wake_on_change_ctrl;
    logic weak_pullup_ctrl;
    logic timer_clock_source;
    logic timer_edge_select;
    logic scaler_assign;
    logic [2:0] scale_ratio;
  } rwsc_option_t;

  typedef struct packed {
    logic pin_change_wake_flag;
    logic timeout_flag;
    logic powerdown_flag;
  } rwsc_cause_t;

  typedef struct packed {
    logic [3:0] opcode;
    logic dest;
    logic [4:0] file_sel;
    logic [2:0] bit_sel;
    logic [8:0] literal;
  } rwsc_decode_t;

  typedef enum logic [1:0] {RWSC_RESET, RWSC_RUN, RWSC_SLEEP} rwsc_state_t;
endpackage

/* File: logic/rwsc_ctrl.sv */
// Purpose: Power-on reset latch, reset timer, watchdog, sleep and wake.
// Assumes: All inputs synchronous to ref_clk; rst models power-up.
// Notes: Reset timer and watchdog count ref_clk, which keeps running in
//        sleep and stands for the on-chip free-running clock.
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
module rwsc_ctrl #(
  parameter int unsigned RST_TIMER_COUNT = rwsc_pkg::RST_TIMER_CYCLES,
  parameter int unsigned WDT_COUNT = rwsc_pkg::WDT_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reset_pin_n,
  input wire logic external_reset_pin_function,
  input wire logic wdt_enable,
  input wire logic code_protect,
  input wire logic prog_verify_mode,
  input wire logic [9:0] prog_addr,
  input wire logic clear_watchdog_instr,
  input wire logic sleep_instr,
  input wire logic portb_access,
  input wire logic [3:0] portb_wake_pins,
  input wire logic [11:0] instr_word,
  input wire logic [5:0] port_drive_in,
  input wire logic [5:0] port_oe_in,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic chip_reset,
  output logic osc_run,
  output logic reset_pin_drive_oe,
  output logic [5:0] port_drive_out,
  output logic [5:0] port_oe_out,
  output logic prog_read_ok,
  output logic id_access_ok,
  output logic [11:0] id_write_mask,
  output rwsc_pkg::rwsc_decode_t instr_fields,
  output logic prescale_to_timer
);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic [7:0] ratio_max(input logic [2:0] ps);
    ratio_max = 8'(({7'h00, 1'b1} << ps) - 8'h01);
  endfunction

  // ---------------------------------------------------------------
  // State and options
  // ---------------------------------------------------------------
  rwsc_pkg::rwsc_state_t state;
  rwsc_pkg::rwsc_option_t option;
  rwsc_pkg::rwsc_cause_t cause;
  logic [31:0] rst_timer_cnt;
  logic [31:0] wdt_cnt;
  logic [7:0] scaler;
  logic [3:0] pin_snapshot;
  logic wdt_tick;
  logic wdt_timeout;
  logic pin_change;
  logic pin_reset;
  logic wake;

  assign wdt_tick = wdt_enable && (wdt_cnt == WDT_COUNT - 1);
  // Scaler widens the time-out only when it belongs to the watchdog.
  assign wdt_timeout = wdt_tick &&
    (!option.scaler_assign || scaler == ratio_max(option.scale_ratio));
  assign pin_change = option.wake_on_change_ctrl == 1'b0 &&
    (portb_wake_pins != pin_snapshot);
  assign pin_reset = external_reset_pin_function && !reset_pin_n;
  assign wake = state == rwsc_pkg::RWSC_SLEEP &&
    (pin_reset || wdt_timeout || pin_change);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state <= rwsc_pkg::RWSC_RESET;
      rst_timer_cnt <= '0;
    end
    else
    begin
      unique case (state)
        rwsc_pkg::RWSC_RESET:
        begin
          if (pin_reset)
            rst_timer_cnt <= '0;
          else if (rst_timer_cnt == RST_TIMER_COUNT - 1)
          begin
            rst_timer_cnt <= '0;
            state <= rwsc_pkg::RWSC_RUN;
          end
          else
            rst_timer_cnt <= rst_timer_cnt + 32'd1;
        end
        rwsc_pkg::RWSC_RUN:
        begin
          if (pin_reset || wdt_timeout)
            state <= rwsc_pkg::RWSC_RESET;
          else if (sleep_instr)
            state <= rwsc_pkg::RWSC_SLEEP;
        end
        rwsc_pkg::RWSC_SLEEP:
        begin
          if (wake)
            state <= rwsc_pkg::RWSC_RESET;
        end
      endcase
    end
  end

  // Option register: write-only for software, all ones on every reset.
  always_ff @(posedge ref_clk)
  begin
    if (rst || state == rwsc_pkg::RWSC_RESET)
      option <= rwsc_pkg::OPTION_RESET;
    else if (reg_wr && reg_addr == rwsc_pkg::ADDR_OPTION)
      option <= reg_wdata;
  end

  // ---------------------------------------------------------------
  // Watchdog and shared scaler
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst || wake || state == rwsc_pkg::RWSC_RESET)
      wdt_cnt <= '0;
    else if (clear_watchdog_instr || sleep_instr)
      wdt_cnt <= '0;
    else if (!wdt_enable || wdt_tick)
      wdt_cnt <= '0;
    else
      wdt_cnt <= wdt_cnt + 32'd1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst || wake || state == rwsc_pkg::RWSC_RESET)
      scaler <= '0;
    else if ((clear_watchdog_instr || sleep_instr) && option.scaler_assign)
      scaler <= '0;
    else if (wdt_tick && option.scaler_assign)
      scaler <= wdt_timeout ? 8'h00 : scaler + 8'h01;
  end

  // ---------------------------------------------------------------
  // Reset-cause flags
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      cause <= 3'b011;
    else if (state == rwsc_pkg::RWSC_SLEEP && wake)
    begin
      if (pin_reset)
        cause <= 3'b010;
      else if (wdt_timeout)
        cause <= 3'b000;
      else
        cause <= 3'b110;
    end
    else if (state == rwsc_pkg::RWSC_RUN && wdt_timeout)
      cause <= {1'b0, 1'b0, cause.powerdown_flag};
    else if (state == rwsc_pkg::RWSC_RUN && pin_reset)
      cause <= {1'b0, cause.timeout_flag, cause.powerdown_flag};
    else if (state == rwsc_pkg::RWSC_RUN && sleep_instr)
      cause <= {cause.pin_change_wake_flag, 1'b1, 1'b0};
    else if (state == rwsc_pkg::RWSC_RUN && clear_watchdog_instr)
      cause <= {cause.pin_change_wake_flag, 1'b1, 1'b1};
  end

  // Snapshot of the wake pins taken on each port access while running.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      pin_snapshot <= '0;
    else if (portb_access && state == rwsc_pkg::RWSC_RUN)
      pin_snapshot <= portb_wake_pins;
  end

  // ---------------------------------------------------------------
  // Pins and outputs
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      chip_reset <= 1'b1;
      osc_run <= 1'b0;
      reset_pin_drive_oe <= 1'b0;
      prescale_to_timer <= 1'b0;
    end
    else
    begin
      chip_reset <= state == rwsc_pkg::RWSC_RESET;
      osc_run <= state == rwsc_pkg::RWSC_RUN;
      reset_pin_drive_oe <= 1'b0;
      prescale_to_timer <= !option.scaler_assign;
    end
  end

  // Port drive is frozen while asleep so pins keep their prior state.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      port_drive_out <= '0;
      port_oe_out <= '0;
    end
    else if (state != rwsc_pkg::RWSC_SLEEP)
    begin
      port_drive_out <= port_drive_in;
      port_oe_out <= port_oe_in;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      prog_read_ok <= 1'b0;
      id_access_ok <= 1'b0;
      id_write_mask <= '0;
    end
    else
    begin
      prog_read_ok <= prog_verify_mode && (!code_protect ||
        prog_addr < rwsc_pkg::PROG_OPEN_LIMIT ||
        prog_addr == rwsc_pkg::PROG_LAST);
      id_access_ok <= prog_verify_mode;
      id_write_mask <= rwsc_pkg::ID_UPPER_MASK;
    end
  end

  // Opcode and operand fields of the 12-bit instruction word.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      instr_fields <= '0;
    else
    begin
      instr_fields.opcode <= instr_word[11:8];
      instr_fields.dest <= instr_word[5];
      instr_fields.file_sel <= instr_word[4:0];
      instr_fields.bit_sel <= instr_word[7:5];
      instr_fields.literal <= instr_word[8:0];
    end
  end

  // ---------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      reg_rdata <= '0;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        rwsc_pkg::ADDR_STATUS:
          reg_rdata <= {cause.pin_change_wake_flag, 2'b00,
            cause.timeout_flag, cause.powerdown_flag, 3'b000};
        rwsc_pkg::ADDR_CTRL:
          reg_rdata <= {6'h00, state};
        default:
          reg_rdata <= '0;
      endcase
    end
    else
      reg_rdata <= '0;
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_sleep_flags: assert property (@(posedge ref_clk) disable iff (rst)
    state == rwsc_pkg::RWSC_RUN && sleep_instr && !pin_reset && !wdt_timeout
    |=> cause.timeout_flag && !cause.powerdown_flag)
    else $error("sleep entry flags wrong");
  a_wdt_wake_cause: assert property (@(posedge ref_clk) disable iff (rst)
    state == rwsc_pkg::RWSC_SLEEP && wdt_timeout && !pin_reset
    |=> cause == 3'b000)
    else $error("watchdog wake cause wrong");
  a_wake_clears_wdt: assert property (@(posedge ref_clk) disable iff (rst)
    wake |=> wdt_cnt == 0 && state == rwsc_pkg::RWSC_RESET)
    else $error("wake did not clear watchdog");
  a_clear_watchdog_instr_zero: assert property (@(posedge ref_clk) disable iff (rst)
    clear_watchdog_instr && state == rwsc_pkg::RWSC_RUN |=> wdt_cnt == 0)
    else $error("clear watchdog failed");
  a_pin_no_drive: assert property (@(posedge ref_clk) disable iff (rst)
    !reset_pin_drive_oe)
    else $error("reset pin driven");
  a_sleep_hold: assert property (@(posedge ref_clk) disable iff (rst)
    state == rwsc_pkg::RWSC_SLEEP && $past(state) == rwsc_pkg::RWSC_SLEEP
    |=> $stable(port_drive_out) && $stable(port_oe_out))
    else $error("port state changed in sleep");
  a_timeout_reset: assert property (@(posedge ref_clk) disable iff (rst)
    state == rwsc_pkg::RWSC_RUN && wdt_timeout |=> ##1 chip_reset)
    else $error("watchdog time-out no reset");
  a_hold_in_reset: assert property (@(posedge ref_clk) disable iff (rst)
    state == rwsc_pkg::RWSC_RESET && pin_reset |=> ##1 chip_reset)
    else $error("reset ended while pin low");
  a_readout_gate: assert property (@(posedge ref_clk) disable iff (rst)
    prog_verify_mode && !code_protect |=> prog_read_ok)
    else $error("readout refused");

  c_sleep_entry: cover property (@(posedge ref_clk) disable iff (rst)
    state == rwsc_pkg::RWSC_RUN && sleep_instr);
  c_pin_wake: cover property (@(posedge ref_clk) disable iff (rst)
    wake && pin_change);
  c_wdt_wake: cover property (@(posedge ref_clk) disable iff (rst)
    wake && wdt_timeout);
  c_reset_end: cover property (@(posedge ref_clk) disable iff (rst)
    state == rwsc_pkg::RWSC_RESET ##1 state == rwsc_pkg::RWSC_RUN);

endmodule
`default_nettype wire

/* File: verification/rwsc_far_side.sv */
// Purpose: Far side of the controller: the reset pin and the port-B wake pins.
// Assumes: The bench moves the requests just after a rising ref_clk edge.
// Notes: The reset pin has a weak pull-up, so it reads high once released.
`timescale 1ns/100ps
`default_nettype none
module rwsc_far_side
(
  input wire logic ref_clk,
  input wire logic pull_low,
  input wire logic flip_pin,
  output logic reset_pin_n,
  output logic [3:0] portb_wake_pins
);
  // The pin is never left floating, so the pull-up level shows on release.
  assign reset_pin_n = !pull_low;
  initial portb_wake_pins = 4'h0;
  always @(posedge ref_clk)
  begin
    if (flip_pin)
    begin
      portb_wake_pins <= portb_wake_pins ^ 4'h4;
    end
  end
endmodule
`default_nettype wire

/* File: verification/rwsc_ctrl_tb.sv */
// Purpose: Self-checking bench for the reset, watchdog and sleep controller.
// Assumes: Short counts RST_TIMER_COUNT 50 and WDT_COUNT 20 stand for 18 ms.
// Notes: Decode and readout cases run from a table, the rest by hand.
`timescale 1ns/100ps
`default_nettype none
module rwsc_ctrl_tb;
  typedef struct packed {
    logic [11:0] iw;
    logic cp;
    logic [9:0] pa;
    logic pv;
    logic [4:0] fs;
    logic d;
    logic [2:0] bs;
    logic [8:0] lit;
    logic pr;
  } rwsc_row_t;
  rwsc_row_t rows [5];
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic pull_low = 1'b1;
  logic flip_pin = 1'b0;
  logic reset_pin_n;
  logic [3:0] portb_wake_pins;
  logic external_reset_pin_function = 1'b1;
  logic wdt_enable = 1'b0;
  logic code_protect = 1'b0;
  logic prog_verify_mode = 1'b0;
  logic [9:0] prog_addr = 10'h000;
  logic clear_watchdog_instr = 1'b0;
  logic sleep_instr = 1'b0;
  logic portb_access = 1'b0;
  logic [11:0] instr_word = 12'h000;
  logic [5:0] port_drive_in = 6'h00;
  logic [5:0] port_oe_in = 6'h00;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic chip_reset, osc_run, reset_pin_drive_oe, prog_read_ok, id_access_ok;
  logic [5:0] port_drive_out, port_oe_out;
  logic [11:0] id_write_mask;
  rwsc_pkg::rwsc_decode_t instr_fields;
  logic prescale_to_timer;
  int fails = 0;
  int comparisons = 0;
  int n;

  always #10 ref_clk = ~ref_clk;

  rwsc_far_side far (.ref_clk, .pull_low, .flip_pin, .reset_pin_n,
    .portb_wake_pins);
  rwsc_ctrl #(.RST_TIMER_COUNT(50), .WDT_COUNT(20)) DUT (.ref_clk, .rst,
    .reset_pin_n, .external_reset_pin_function, .wdt_enable, .code_protect,
    .prog_verify_mode, .prog_addr, .clear_watchdog_instr, .sleep_instr,
    .portb_access, .portb_wake_pins, .instr_word, .port_drive_in,
    .port_oe_in, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .chip_reset, .osc_run, .reset_pin_drive_oe, .port_drive_out,
    .port_oe_out, .prog_read_ok, .id_access_ok, .id_write_mask,
    .instr_fields, .prescale_to_timer);

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk({4'h0, reg_rdata}, {4'h0, exp});
  endtask

  // Pulse kinds: 0 clear-watchdog, 1 sleep, 2 port access.
  task automatic pulse(input int k);
    @(posedge ref_clk);
    clear_watchdog_instr <= (k == 0);
    sleep_instr <= (k == 1);
    portb_access <= (k == 2);
    @(posedge ref_clk);
    {clear_watchdog_instr, sleep_instr, portb_access} <= 3'b000;
  endtask

  task automatic wait_chip(input logic v, input int lim);
    n = 0;
    while (chip_reset !== v && n < lim)
    begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (chip_reset !== v)
    begin
      fails++;
      $display("[ERR] t=%0t wait expired, reset level %h", $time, v);
      wrap_up();
    end
  endtask

  initial
  begin
    rows[0] = {12'h02a, 1'b1, 10'h03f, 1'b1, 5'h0a, 1'b1, 3'h1, 9'h02a, 1'b1};
    rows[1] = {12'h1c5, 1'b1, 10'h040, 1'b1, 5'h05, 1'b0, 3'h6, 9'h1c5, 1'b0};
    rows[2] = {12'hcff, 1'b1, 10'h3ff, 1'b1, 5'h1f, 1'b1, 3'h7, 9'h0ff, 1'b1};
    rows[3] = {12'h9e0, 1'b0, 10'h200, 1'b1, 5'h00, 1'b1, 3'h7, 9'h1e0, 1'b1};
    rows[4] = {12'h4b3, 1'b0, 10'h100, 1'b0, 5'h13, 1'b1, 3'h5, 9'h0b3, 1'b0};
    tick(12);
    rst <= 1'b0;
    // -----------------------------------------------------------------
    // Power-up with the reset pin held low
    // -----------------------------------------------------------------
    tick(80);
    #1 chk(chip_reset, 1);
    rd(rwsc_pkg::ADDR_STATUS, 8'h18);
    rd(rwsc_pkg::ADDR_OPTION, 8'h00);
    rd(4'hf, 8'h00);
    chk(prescale_to_timer, 0);
    @(posedge ref_clk);
    pull_low <= 1'b0;
    wait_chip(0, 100);
    chk(n >= 49 && n <= 53, 1);
    chk(osc_run, 1);
    $display("test power-up done");
    foreach (rows[i])
    begin
      @(posedge ref_clk);
      {instr_word, code_protect, prog_addr, prog_verify_mode} <=
        {rows[i].iw, rows[i].cp, rows[i].pa, rows[i].pv};
      tick(2);
      #1 chk(instr_fields.file_sel, rows[i].fs);
      chk(instr_fields.dest, rows[i].d);
      chk({instr_fields.bit_sel, instr_fields.literal},
        {rows[i].bs, rows[i].lit});
      chk(id_access_ok, rows[i].pv);
      if (rows[i].pv)
        chk(prog_read_ok, rows[i].pr);
    end
    chk(id_write_mask, 12'h00f);
    $display("test table done");
    // -----------------------------------------------------------------
    // Watchdog with and without the scaler
    // -----------------------------------------------------------------
    wr(rwsc_pkg::ADDR_OPTION, 8'h07);
    wdt_enable <= 1'b1;
    tick(2);
    #1 chk(prescale_to_timer, 1);
    repeat (10)
    begin
      pulse(0);
      tick(8);
      #1 chk(chip_reset, 0);
    end
    rd(rwsc_pkg::ADDR_STATUS, 8'h18);
    wait_chip(1, 40);
    chk(n, 11);
    chk(reset_pin_drive_oe, 0);
    rd(rwsc_pkg::ADDR_STATUS, 8'h08);
    wait_chip(0, 80);
    wr(rwsc_pkg::ADDR_OPTION, 8'h09);
    wait_chip(1, 70);
    chk(n >= 33, 1);
    wait_chip(0, 80);
    $display("test watchdog done");
    // -----------------------------------------------------------------
    // Sleep and the three wake sources
    // -----------------------------------------------------------------
    wr(rwsc_pkg::ADDR_OPTION, 8'h07);
    pulse(1);
    tick(2);
    #1 chk(osc_run, 0);
    rd(rwsc_pkg::ADDR_STATUS, 8'h10);
    wait_chip(1, 40);
    chk(n >= 12, 1);
    rd(rwsc_pkg::ADDR_STATUS, 8'h00);
    wait_chip(0, 80);
    wdt_enable <= 1'b0;
    port_drive_in <= 6'h15;
    port_oe_in <= 6'h3c;
    wr(rwsc_pkg::ADDR_OPTION, 8'h07);
    pulse(2);
    pulse(1);
    port_drive_in <= 6'h2a;
    port_oe_in <= 6'h03;
    tick(3);
    #1 chk({port_oe_out, port_drive_out}, 12'hf15);
    @(posedge ref_clk);
    flip_pin <= 1'b1;
    @(posedge ref_clk);
    flip_pin <= 1'b0;
    wait_chip(1, 10);
    rd(rwsc_pkg::ADDR_STATUS, 8'h90);
    wait_chip(0, 80);
    pull_low <= 1'b1;
    tick(3);
    pull_low <= 1'b0;
    wait_chip(0, 80);
    rd(rwsc_pkg::ADDR_STATUS, 8'h10);
    pulse(0);
    pulse(1);
    pull_low <= 1'b1;
    wait_chip(1, 10);
    pull_low <= 1'b0;
    rd(rwsc_pkg::ADDR_STATUS, 8'h10);
    wait_chip(0, 80);
    $display("test sleep done");
    wrap_up();
  end
endmodule
`default_nettype wire
